// *** verilog/uitmr_consts.svh ***
// constants for the interrupt aggregation and counter/timer block
// assumes inclusion by bare name from design files
`ifndef UITMR_CONSTS_SVH
`define UITMR_CONSTS_SVH
// ****************************************
// register addresses (four address lines)
// ****************************************
`define UITMR_ADDR_MASK 4'h5
`define UITMR_ADDR_PRE_HI 4'h6
`define UITMR_ADDR_PRE_LO 4'h7
`define UITMR_ADDR_VECTOR 4'hC
`define UITMR_ADDR_START 4'hE
`define UITMR_ADDR_STOP 4'hF
`define UITMR_ADDR_INCHG 4'h4
// ****************************************
// cause flag bit positions
// ****************************************
`define UITMR_BIT_TX_A 0
`define UITMR_BIT_RX_A 1
`define UITMR_BIT_BRK_A 2
`define UITMR_BIT_CTR 3
`define UITMR_BIT_TX_B 4
`define UITMR_BIT_RX_B 5
`define UITMR_BIT_BRK_B 6
`define UITMR_BIT_INPORT 7
// ****************************************
// reset values
// ****************************************
`define UITMR_VECTOR_RESET 8'h0F
`define UITMR_MASK_RESET 8'h00
`define UITMR_PRESET_RESET 16'h0002
`define UITMR_READ_IDLE 8'h00
`endif

// *** verilog/uitmr_pkg.sv ***
// types shared by the interrupt and counter/timer block
// assumes no surroundings beyond the compile order
package uitmr_pkg;
    typedef logic [7:0] uitmr_byte_t;
    typedef enum logic [1:0] {UITMR_IDLE, UITMR_RUN} uitmr_state_e;
endpackage

// *** verilog/uitmr_flag.sv ***
// one sticky cause flag with set-over-clear priority
// assumes set and clear are single-cycle pulses in the clock domain
`timescale 1ns/10ps
`default_nettype none
module uitmr_flag (
    input wire logic clock,
    input wire logic rst,
    input wire logic set_pulse,
    input wire logic clear_pulse,
    output logic flag
);
    // a set landing with a clear wins so no event is lost
    always_ff @(posedge clock) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clear_pulse) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** verilog/uitmr_timer.sv ***
// timer-mode down counter producing a square wave and a cycle pulse
// assumes tick is a one-cycle enable from the counter/timer clock source
`timescale 1ns/10ps
`default_nettype none
module uitmr_timer
    import uitmr_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic [WIDTH-1:0] preset,
    output logic running,
    output logic square_out,
    output logic cycle_done
);
    logic [WIDTH-1:0] count_reg;
    uitmr_state_e state_reg;
    logic at_end;

    assign at_end = (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    assign running = (state_reg == UITMR_RUN);

    // idle after reset; start reloads; then free running
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= UITMR_IDLE;
        end else if (start) begin
            state_reg <= UITMR_RUN;
        end
    end

    // preset sampled at start and at each half-period boundary
    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= '0;
            square_out <= 1'b1;
            cycle_done <= 1'b0;
        end else begin
            cycle_done <= 1'b0;
            if (start) begin
                count_reg <= preset;
                square_out <= 1'b1;
            end else if (running && tick) begin
                if (at_end) begin
                    count_reg <= preset;
                    square_out <= ~square_out;
                    cycle_done <= ~square_out; // once per full cycle
                end else begin
                    count_reg <= count_reg - 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/uitmr_top.sv ***
// interrupt aggregation and counter/timer of a dual serial controller
// assumes a synchronous bus: one-cycle read/write strobes, 4 address lines
// Summary of operation
// - channel A break start or end sets cause bit 2.
// - cause bit 2 clears only on channel A reset-break-change command.
// - channel A receive threshold or watchdog asserts cause bit 1.
// - channel A transmit level reached asserts cause bit 0.
// - rx/tx cause bits are independent of channel status ready bits.
// - interrupt request active when any cause and its mask bit are set.
// - a masked-off cause never affects the interrupt request.
// - mask gates only the request, not output pins or cause reads.
// - mask bits 7..0 follow cause layout; a one enables.
// - vector byte resets to 0x0F and holds host writes.
// - vector byte driven on acknowledge low or a read at 0xC.
// - outside vectored mode the vector byte is plain scratch storage.
// - 16-bit preset: high byte at 0x6, low byte at 0x7.
// - preset bytes are write-only; reads do not return them.
// - timer square wave period is twice the preset in timer clocks.
// - timer idles after reset until a read at address 1110.
// - once started the timer runs with no further commands.
// - each start aborts the current cycle and reloads the preset.
// - a preset rewrite takes effect at the next half-period.
// - counter-ready bit 3 set each wave cycle; stop read clears it.
// - input change bit 7 set on enabled change, cleared on its read.
`timescale 1ns/10ps
`default_nettype none
`include "uitmr_consts.svh"
module uitmr_top
    import uitmr_pkg::*;
#(
    parameter int PRESET_WIDTH = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic [7:0] bus_data_oe_n,
    input wire logic irq_acknowledge_in_n,
    input wire logic vectored_bus_mode,
    input wire logic ct_tick,
    input wire logic brk_a_change,
    input wire logic brk_a_reset_cmd,
    input wire logic rx_a_irq_flag,
    input wire logic tx_a_irq_flag,
    input wire logic brk_b_change,
    input wire logic brk_b_reset_cmd,
    input wire logic rx_b_irq_flag,
    input wire logic tx_b_irq_flag,
    input wire logic inport_change,
    output logic irq_request_out_n,
    output logic [7:0] interrupt_cause_flags,
    output logic timer_square_out,
    output logic timer_running
);
    // ****************************************
    // register map seen by the host
    // ****************************************
    // 0x4 read  : idle value; the read clears cause bit 7
    // 0x5 read  : cause flags, never masked
    // 0x5 write : enable mask, one bit per cause, a one enables
    // 0x6 write : upper preset byte, write-only
    // 0x7 write : lower preset byte, write-only
    // 0xC r/w   : vector byte, scratch byte outside vectored mode
    // 0xE read  : start command, restarts the timer from the preset
    // 0xF read  : stop command, clears cause bit 3, timer keeps running
    // all other addresses read as the idle value and ignore writes
    //
    // every strobe is taken on the edge that samples it; read data and the
    // bus enable follow one cycle later, the request pin one cycle after that
    // for a mask write and two cycles after that for a cause-clearing read

    // ****************************************
    // register storage and decode
    // ****************************************
    uitmr_byte_t interrupt_enable_mask_reg;
    uitmr_byte_t irq_vector_byte_reg;
    uitmr_byte_t timer_preload_high_reg;
    uitmr_byte_t timer_preload_low_reg;
    uitmr_byte_t read_mux;
    logic start_cmd;
    logic stop_cmd;
    logic inchg_read;
    logic ctr_cycle;
    logic brk_a_flag;
    logic brk_b_flag;
    logic ctr_flag;
    logic inport_flag;
    logic irq_any;
    logic irq_request_next;
    logic bus_drive;
    logic wr_mask;
    logic wr_vector;
    logic wr_pre_hi;
    logic wr_pre_lo;
    logic tx_a_cause_reg;
    logic rx_a_cause_reg;
    logic tx_b_cause_reg;
    logic rx_b_cause_reg;
    logic brk_a_cause_reg;
    logic ctr_cause_reg;
    logic brk_b_cause_reg;
    logic inport_cause_reg;

    // address match on a qualified strobe
    function automatic logic hit(input logic strobe, input logic [3:0] a,
                                 input logic [3:0] want);
        hit = strobe && (a == want);
    endfunction

    assign start_cmd = hit(bus_read, bus_addr, `UITMR_ADDR_START);
    assign stop_cmd = hit(bus_read, bus_addr, `UITMR_ADDR_STOP);
    assign inchg_read = hit(bus_read, bus_addr, `UITMR_ADDR_INCHG);

    // write strobes decoded once so each register block stays simple
    assign wr_mask = hit(bus_write, bus_addr, `UITMR_ADDR_MASK);
    assign wr_vector = hit(bus_write, bus_addr, `UITMR_ADDR_VECTOR);
    assign wr_pre_hi = hit(bus_write, bus_addr, `UITMR_ADDR_PRE_HI);
    assign wr_pre_lo = hit(bus_write, bus_addr, `UITMR_ADDR_PRE_LO);

    // mask written at 0x5, cleared by reset
    always_ff @(posedge clock) begin
        if (rst) begin
            interrupt_enable_mask_reg <= `UITMR_MASK_RESET;
        end else if (wr_mask) begin
            interrupt_enable_mask_reg <= bus_wdata;
        end
    end

    // vector byte doubles as scratch storage in strobed bus mode
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_vector_byte_reg <= `UITMR_VECTOR_RESET;
        end else if (wr_vector) begin
            irq_vector_byte_reg <= bus_wdata;
        end
    end

    // preset halves; reset value respects the smallest legal preset
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_preload_high_reg <= 8'(`UITMR_PRESET_RESET >> 8);
            timer_preload_low_reg <= 8'(`UITMR_PRESET_RESET);
        end else begin
            if (wr_pre_hi) begin
                timer_preload_high_reg <= bus_wdata;
            end
            if (wr_pre_lo) begin
                timer_preload_low_reg <= bus_wdata;
            end
        end
    end

    // ****************************************
    // cause flags
    // ****************************************
    // break flags are sticky until the channel command clears them
    uitmr_flag u_brk_a (
        .clock(clock),
        .rst(rst),
        .set_pulse(brk_a_change),
        .clear_pulse(brk_a_reset_cmd),
        .flag(brk_a_flag)
    );
    uitmr_flag u_brk_b (
        .clock(clock),
        .rst(rst),
        .set_pulse(brk_b_change),
        .clear_pulse(brk_b_reset_cmd),
        .flag(brk_b_flag)
    );
    uitmr_flag u_ctr (
        .clock(clock),
        .rst(rst),
        .set_pulse(ctr_cycle),
        .clear_pulse(stop_cmd),
        .flag(ctr_flag)
    );
    uitmr_flag u_inport (
        .clock(clock),
        .rst(rst),
        .set_pulse(inport_change),
        .clear_pulse(inchg_read),
        .flag(inport_flag)
    );

    // channel A rx/tx bits are level images of the interrupt sources,
    // not of the status ready bits, so they track the source directly
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_a_cause_reg <= 1'b0;
            rx_a_cause_reg <= 1'b0;
        end else begin
            tx_a_cause_reg <= tx_a_irq_flag;
            rx_a_cause_reg <= rx_a_irq_flag;
        end
    end

    // channel B level sources follow the same one-cycle image
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_b_cause_reg <= 1'b0;
            rx_b_cause_reg <= 1'b0;
        end else begin
            tx_b_cause_reg <= tx_b_irq_flag;
            rx_b_cause_reg <= rx_b_irq_flag;
        end
    end

    // sticky flags are retimed too so every cause bit comes from a flop, two edges
    // after its pulse against one for the levels; a read sees one consistent snapshot
    always_ff @(posedge clock) begin
        if (rst) begin
            brk_a_cause_reg <= 1'b0;
            ctr_cause_reg <= 1'b0;
            brk_b_cause_reg <= 1'b0;
            inport_cause_reg <= 1'b0;
        end else begin
            brk_a_cause_reg <= brk_a_flag;
            ctr_cause_reg <= ctr_flag;
            brk_b_cause_reg <= brk_b_flag;
            inport_cause_reg <= inport_flag;
        end
    end

    // cause register assembled from flops, bit 7 down to bit 0
    assign interrupt_cause_flags = {
        inport_cause_reg,
        brk_b_cause_reg,
        rx_b_cause_reg,
        tx_b_cause_reg,
        ctr_cause_reg,
        brk_a_cause_reg,
        rx_a_cause_reg,
        tx_a_cause_reg
    };

    // ****************************************
    // interrupt request
    // ****************************************
    // mask touches only this output; cause reads stay unmasked
    assign irq_any = |(interrupt_cause_flags & interrupt_enable_mask_reg);
    assign irq_request_next = ~irq_any;

    // registered so the request pin never glitches while causes settle
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_request_out_n <= 1'b1;
        end else begin
            irq_request_out_n <= irq_request_next;
        end
    end

    // ****************************************
    // counter/timer
    // ****************************************
    uitmr_timer #(
        .WIDTH(PRESET_WIDTH)
    ) u_timer (
        .clock(clock),
        .rst(rst),
        .tick(ct_tick),
        .start(start_cmd),
        .preset({timer_preload_high_reg, timer_preload_low_reg}),
        .running(timer_running),
        .square_out(timer_square_out),
        .cycle_done(ctr_cycle)
    );

    // ****************************************
    // read path
    // ****************************************
    // preset addresses fall to the idle value so stored bytes never leak
    always_comb begin
        read_mux = `UITMR_READ_IDLE;
        if (!irq_acknowledge_in_n) begin
            read_mux = irq_vector_byte_reg;
        end else begin
            unique case (bus_addr)
                `UITMR_ADDR_MASK: read_mux = interrupt_cause_flags;
                `UITMR_ADDR_VECTOR: read_mux = irq_vector_byte_reg;
                `UITMR_ADDR_PRE_HI: read_mux = `UITMR_READ_IDLE;
                `UITMR_ADDR_PRE_LO: read_mux = `UITMR_READ_IDLE;
                default: read_mux = `UITMR_READ_IDLE;
            endcase
        end
    end

    // the bus is driven for a read strobe or an acknowledge, nothing else
    assign bus_drive = bus_read || !irq_acknowledge_in_n;

    // read data registered so the bus sees a settled byte
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_rdata <= `UITMR_READ_IDLE;
        end else begin
            bus_rdata <= read_mux;
        end
    end

    // enable low while driving; released the cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst) begin
            bus_data_oe_n <= 8'hFF;
        end else begin
            bus_data_oe_n <= bus_drive ? 8'h00 : 8'hFF;
        end
    end

    // ****************************************
    // limitations
    // ****************************************
    // the mode pin is carried for the system only: the vector byte keeps
    // the same read/write behaviour in both bus modes, which is what the
    // scratch use outside vectored mode needs anyway
    // counter mode is not built; the timer always makes a square wave
    // presets below two are the host's to avoid; one would toggle at the
    // tick rate and zero would count through the whole range first
endmodule
`default_nettype wire

// *** tb/uitmr_chk.sv ***
// assertions for the interrupt and counter/timer block
// assumes a bind onto the top module with ports matched by name
`timescale 1ns/10ps
`default_nettype none
module uitmr_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] bus_addr,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] bus_data_oe_n,
    input wire logic irq_acknowledge_in_n,
    input wire logic brk_a_change,
    input wire logic brk_a_reset_cmd,
    input wire logic tx_a_irq_flag,
    input wire logic irq_request_out_n,
    input wire logic [7:0] interrupt_cause_flags,
    input wire logic timer_running
);
    // ****************
    // shadows and properties
    // ****************
    logic [7:0] mask_reg;
    logic [7:0] vec_reg;
    wire logic [7:0] cf = interrupt_cause_flags;
    wire logic rd_ok = bus_read && irq_acknowledge_in_n;
    // shadows follow host writes, so nothing is read out of the design
    always_ff @(posedge clock) begin
        if (rst) begin
            mask_reg <= 8'h00;
            vec_reg <= 8'h0F;
        end else if (bus_write && bus_addr == 4'h5) begin
            mask_reg <= bus_wdata;
        end else if (bus_write && bus_addr == 4'hC) begin
            vec_reg <= bus_wdata;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_req; !$past(rst) |-> irq_request_out_n == ~|$past(cf & mask_reg);
    endproperty
    property p_tx; !$past(rst) |-> cf[0] == $past(tx_a_irq_flag); endproperty
    // flag module then cause register: two edges from pulse to cause bit
    property p_brk; brk_a_change |-> ##2 cf[2]; endproperty
    property p_hold; cf[2] && !brk_a_reset_cmd && !$past(brk_a_reset_cmd)
        |=> cf[2]; endproperty
    property p_vec; bus_read && bus_addr == 4'hC || !irq_acknowledge_in_n
        |=> bus_rdata == $past(vec_reg) && bus_data_oe_n == 8'h00; endproperty
    property p_pre; rd_ok && bus_addr[3:1] == 3'b011 |=> bus_rdata == 8'h00;
    endproperty
    property p_cause; rd_ok && bus_addr == 4'h5 |=> bus_rdata == $past(cf);
    endproperty
    // running only ever follows a start read or an earlier run
    property p_run; !$past(rst) |-> timer_running ==
        $past(timer_running || bus_read && bus_addr == 4'hE); endproperty
    a_req: assert property (p_req)
        else $error("request disagrees with cause and mask");
    a_tx: assert property (p_tx)
        else $error("transmit cause does not follow its source");
    a_brk: assert property (p_brk)
        else $error("break change did not set its cause");
    a_hold: assert property (p_hold)
        else $error("break cause dropped without its reset command");
    a_vec: assert property (p_vec)
        else $error("vector byte not returned");
    a_pre: assert property (p_pre)
        else $error("preset byte readable");
    a_cause: assert property (p_cause)
        else $error("cause read returned wrong value");
    a_run: assert property (p_run)
        else $error("timer run state wrong");
    c_irq: cover property (!irq_request_out_n);
    c_ack: cover property (!irq_acknowledge_in_n);
    c_run: cover property ($rose(timer_running));
endmodule
`default_nettype wire

// *** tb/uitmr_host.sv ***
// host bus model: one-cycle read and write strobes
// assumes the device samples the strobes on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module uitmr_host (
    input wire logic clock,
    input wire logic [7:0] bus_rdata,
    output logic [3:0] bus_addr,
    output logic bus_read,
    output logic bus_write,
    output logic [7:0] bus_wdata,
    output logic irq_acknowledge_in_n
);
    // ****************
    // bus cycles
    // ****************
    // idle bus from time zero
    initial begin
        bus_addr = 4'h0;
        bus_read = 1'b0;
        bus_write = 1'b0;
        bus_wdata = 8'h00;
        irq_acknowledge_in_n = 1'b1;
    end
    // released lines are scrambled so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
    endtask
    // k high makes an acknowledge cycle instead of a read
    task automatic rd(input logic [3:0] a, input logic k, output logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_read <= ~k;
        irq_acknowledge_in_n <= ~k;
        @(posedge clock);
        bus_read <= 1'b0;
        irq_acknowledge_in_n <= 1'b1;
        bus_addr <= ~a;
        @(negedge clock);
        d = bus_rdata;
    endtask
endmodule
`default_nettype wire

// *** tb/uart_irq_and_timer_test.sv ***
// self-checking bench for the interrupt and counter/timer block
// assumes the host model owns the bus and the bench owns event inputs
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module uart_irq_and_timer_test;
    // ****************
    // signals and instances
    // ****************
    logic clock;
    logic rst = 1'b1;
    logic vectored_bus_mode = 1'b0;
    logic ct_tick = 1'b1;
    logic [7:0] lv = 8'h00;
    logic [7:0] pl = 8'h00;
    logic [7:0] cl = 8'h00;
    logic [7:0] d;
    wire logic [3:0] bus_addr;
    wire logic bus_read, bus_write, irq_acknowledge_in_n;
    wire logic [7:0] bus_wdata, bus_rdata, bus_data_oe_n, cf;
    wire logic irq_request_out_n, timer_square_out, timer_running;
    wire logic tx_a_irq_flag = lv[0];
    wire logic rx_a_irq_flag = lv[1];
    wire logic tx_b_irq_flag = lv[4];
    wire logic rx_b_irq_flag = lv[5];
    wire logic brk_a_change = pl[2];
    wire logic brk_b_change = pl[6];
    wire logic inport_change = pl[7];
    wire logic brk_a_reset_cmd = cl[2];
    wire logic brk_b_reset_cmd = cl[6];
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int tog = 0;
    uitmr_top #(.PRESET_WIDTH(16)) i_uitmr_top (
        .interrupt_cause_flags(cf), .*);
    uitmr_host i_uitmr_host (.*);
    // free-running clock; edge count times the square wave
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    // raise or clear one cause source; levels, pulses or clearing read
    task automatic src(input int i, input logic on);
        @(posedge clock);
        if (i inside {0, 1, 4, 5}) lv[i] <= on;
        else if (on) pl[i] <= 1'b1;
        else cl[i] <= 1'b1;
        @(posedge clock);
        pl <= 8'h00;
        cl <= 8'h00;
        if (i == 7 && !on) i_uitmr_host.rd(4'h4, 1'b0, d);
    endtask
    // edges since the last toggle; bounded so a dead timer cannot hang
    task automatic wait_tog(output int n);
        logic s;
        s = timer_square_out;
        for (int k = 0; k < 50 && timer_square_out === s; k++) begin
            @(posedge clock);
            #1;
        end
        n = cyc - tog;
        tog = cyc;
    endtask
    task automatic t_mask;
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            if (i == 3) continue;
            b = 8'h01 << i;
            src(i, 1'b1);
            i_uitmr_host.wr(4'h5, ~b);
            repeat (2) @(negedge clock);
            `CHK(irq_request_out_n, 1'b1)
            i_uitmr_host.wr(4'h5, b);
            repeat (2) @(negedge clock);
            `CHK(irq_request_out_n, 1'b0)
            i_uitmr_host.rd(4'h5, 1'b0, d);
            `CHK(d, b)
            src(i, 1'b0);
            repeat (2) @(negedge clock);
            `CHK(cf, 8'h00)
        end
        $display("mask test done");
    endtask
    task automatic t_vec;
        logic [7:0] e;
        i_uitmr_host.rd(4'hC, 1'b0, d);
        `CHK(d, 8'h0F)
        i_uitmr_host.wr(4'h6, 8'h12);
        i_uitmr_host.wr(4'h7, 8'h34);
        for (int m = 0; m < 2; m++) begin
            e = m ? 8'h5A : 8'hA5;
            @(posedge clock);
            vectored_bus_mode <= m[0];
            i_uitmr_host.wr(4'hC, e);
            i_uitmr_host.rd(4'hC, 1'b0, d);
            `CHK(d, e)
            i_uitmr_host.rd(4'h3, 1'b1, d);
            `CHK(d, e)
        end
        i_uitmr_host.rd(4'h6, 1'b0, d);
        `CHK(d, 8'h00)
        i_uitmr_host.rd(4'h7, 1'b0, d);
        `CHK(d, 8'h00)
        $display("vector test done");
    endtask
    task automatic t_timer;
        int n;
        i_uitmr_host.wr(4'h6, 8'h00);
        i_uitmr_host.wr(4'h7, 8'h03);
        repeat (10) @(negedge clock);
        `CHK(timer_running, 1'b0)
        i_uitmr_host.rd(4'hE, 1'b0, d);
        tog = cyc;
        wait_tog(n);
        `CHK(n, 3)
        wait_tog(n);
        `CHK(n, 3)
        i_uitmr_host.wr(4'h7, 8'h05);
        wait_tog(n);
        `CHK(n, 3)
        wait_tog(n);
        `CHK(n, 5)
        while (timer_square_out === 1'b1) wait_tog(n);
        repeat (3) @(negedge clock);
        `CHK(cf[3], 1'b1)
        i_uitmr_host.rd(4'hF, 1'b0, d);
        @(negedge clock);
        `CHK(cf[3], 1'b0)
        `CHK(timer_running, 1'b1)
        wait_tog(n);
        i_uitmr_host.rd(4'hE, 1'b0, d);
        tog = cyc;
        wait_tog(n);
        `CHK(n, 5)
        $display("timer test done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence: reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        lv <= 8'h01;
        repeat (3) @(negedge clock);
        `CHK(cf, 8'h01)
        `CHK(irq_request_out_n, 1'b1)
        $display("reset test done");
        t_mask;
        t_vec;
        t_timer;
        print_verdict;
    end
    // the tests need well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        print_verdict;
    end
endmodule
bind uitmr_top uitmr_chk i_uitmr_chk (.*);
`default_nettype wire
